// file: common/cop_pkg.sv
// Offsets, field layouts and codes for the clock output and multiplier override registers
`default_nettype none
package cop_pkg;
  // Register offsets on the register port
  localparam logic [7:0] PREEMPH_OFS = 8'h48;
  localparam logic [7:0] TRIG_CTRL_OFS = 8'h57;
  localparam logic [7:0] MULT_OVR_OFS = 8'h58;
  // Reset values
  localparam logic [7:0] PREEMPH_RST = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
  localparam logic [7:0] MULT_OVR_RST = 8'h00;
  // Field positions
  localparam int PE_LSB = 0;
  localparam int PE_MSB = 3;
  localparam int TRIG_EN_BIT = 7;
  localparam int TRIG_SEL_LSB = 0;
  localparam int TRIG_SEL_MSB = 2;
  localparam int OVR_EN_BIT = 7;
  localparam int SECOND_SEL_LSB = 4;
  localparam int SECOND_SEL_MSB = 5;
  localparam int FIRST_SEL_LSB = 2;
  localparam int FIRST_SEL_MSB = 3;
  localparam int SE_REF_BIT = 1;
  localparam int MULT_EN_BIT = 0;
  // Trigger output modes
  localparam logic [2:0] TRIG_UI16 = 3'h0;
  localparam logic [2:0] TRIG_UI32 = 3'h1;
  localparam logic [2:0] TRIG_UI64 = 3'h2;
  localparam logic [2:0] TRIG_TSTAMP = 3'h3;
  // Half periods in lane UI ticks for the clock modes
  localparam logic [5:0] HALF_UI16 = 6'h08;
  localparam logic [5:0] HALF_UI32 = 6'h10;
  localparam logic [5:0] HALF_UI64 = 6'h20;
  // Divided reference codes
  localparam logic [1:0] DIVREF_OFF = 2'h0;
  localparam logic [1:0] DIVREF_BY1 = 2'h1;
  localparam logic [1:0] DIVREF_BY2 = 2'h2;
  localparam logic [1:0] DIVREF_BY4 = 2'h3;
  // Synchroniser bit positions for the pin inputs
  localparam int SY_TSTAMP = 0;
  localparam int SY_MEN = 1;
  localparam int SY_REFSEL = 2;
  localparam int SY_CFGA = 3;
  localparam int SY_CFGB = 4;
  localparam int SY_W = 5;
endpackage : cop_pkg
`default_nettype wire

// file: src/cop_regs.sv
// Clock output, pre-emphasis and multiplier override register block
`timescale 1ns/1ps
`default_nettype none

// Contract
// - One 4-bit pre-emphasis code drives all lanes
// - Trigger enable bit 7, resets disabled
// - Mode 0/1/2 clocks 16/32/64 UI, 3 timestamp
// - Override bit selects registers over strap pins
// - Bits 5:4 set second divided output
// - Bits 3:2 set first divided output
// - Without override, strap pins set both outputs
// - Second output needs first output running
// - Bit 1 replaces reference select pin
// - Bit 0 replaces multiplier enable pin
module cop_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Lane and serializer timing
  output logic [3:0] lane_preemphasis_code,
  input wire logic ui_tick,
  input wire logic ser_reinit,
  input wire logic timestamp_in_pair,
  output logic trigger_out_enable,
  output logic [2:0] trigger_out_select,
  output logic trigger_out_pair,
  // Multiplier strap pins
  input wire logic multiplier_enable_pin,
  input wire logic ref_select_pin,
  input wire logic clock_config_pin_a,
  input wire logic clock_config_pin_b,
  // Multiplier controls and divided references
  input wire logic ref_tick,
  output logic multiplier_enable,
  output logic single_ended_ref_select,
  output logic [1:0] first_divref_select,
  output logic [1:0] second_divref_select,
  output logic first_divref_out,
  output logic second_divref_out
);

  typedef struct packed {
    logic [7:0] pe;
    logic [7:0] trig;
    logic [7:0] ovr;
    logic [7:0] rdata;
    logic [cop_pkg::SY_W-1:0] sy1;
    logic [cop_pkg::SY_W-1:0] sy2;
    logic [5:0] tcnt;
    logic tout;
    logic [1:0] rcnt;
    logic cout;
    logic dout;
  } cop_state_s;

  cop_state_s st_ff;
  cop_state_s nxt_st;
  logic [5:0] half;
  logic ovr_en;
  logic [1:0] strap_code;
  logic [1:0] c_code;
  logic [1:0] d_code;
  logic [1:0] c_mask;
  logic [1:0] d_mask;

  function automatic logic [1:0] cop_mask(input logic [1:0] code);
    case (code)
      cop_pkg::DIVREF_BY2: cop_mask = 2'h1;
      cop_pkg::DIVREF_BY4: cop_mask = 2'h3;
      default: cop_mask = 2'h0;
    endcase
  endfunction : cop_mask

  // Strap mapping: both divided outputs follow the two config pins
  assign ovr_en = st_ff.ovr[cop_pkg::OVR_EN_BIT];
  assign strap_code = {st_ff.sy2[cop_pkg::SY_CFGB], st_ff.sy2[cop_pkg::SY_CFGA]};
  assign c_code = ovr_en ? st_ff.ovr[cop_pkg::FIRST_SEL_MSB:cop_pkg::FIRST_SEL_LSB]
                         : strap_code;
  assign d_code = ovr_en ? st_ff.ovr[cop_pkg::SECOND_SEL_MSB:cop_pkg::SECOND_SEL_LSB]
                         : strap_code;
  assign c_mask = cop_mask(c_code);
  assign d_mask = cop_mask(d_code);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sy1 = {clock_config_pin_b, clock_config_pin_a, ref_select_pin,
                  multiplier_enable_pin, timestamp_in_pair};
    nxt_st.sy2 = st_ff.sy1;
    // Full bytes are kept so reserved bits read back as written
    if (reg_wr)
    begin
      case (reg_addr)
        cop_pkg::PREEMPH_OFS: nxt_st.pe = reg_wdata;
        cop_pkg::TRIG_CTRL_OFS: nxt_st.trig = reg_wdata;
        cop_pkg::MULT_OVR_OFS: nxt_st.ovr = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        cop_pkg::PREEMPH_OFS: nxt_st.rdata = st_ff.pe;
        cop_pkg::TRIG_CTRL_OFS: nxt_st.rdata = st_ff.trig;
        cop_pkg::MULT_OVR_OFS: nxt_st.rdata = st_ff.ovr;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    // Trigger output divider
    case (st_ff.trig[cop_pkg::TRIG_SEL_MSB:cop_pkg::TRIG_SEL_LSB])
      cop_pkg::TRIG_UI16: half = cop_pkg::HALF_UI16;
      cop_pkg::TRIG_UI32: half = cop_pkg::HALF_UI32;
      default: half = cop_pkg::HALF_UI64;
    endcase
    if (!st_ff.trig[cop_pkg::TRIG_EN_BIT])
    begin
      nxt_st.tcnt = 6'h00;
      nxt_st.tout = 1'b0;
    end
    else if (st_ff.trig[cop_pkg::TRIG_SEL_MSB:cop_pkg::TRIG_SEL_LSB] == cop_pkg::TRIG_TSTAMP)
    begin
      nxt_st.tcnt = 6'h00;
      nxt_st.tout = st_ff.sy2[cop_pkg::SY_TSTAMP];
    end
    else if (st_ff.trig[cop_pkg::TRIG_SEL_MSB:cop_pkg::TRIG_SEL_LSB] > cop_pkg::TRIG_TSTAMP)
    begin
      nxt_st.tcnt = 6'h00;
      nxt_st.tout = 1'b0;
    end
    else if (ser_reinit)
    begin
      // Clock modes ride on the serializer, so a restart breaks the clock
      nxt_st.tcnt = 6'h00;
      nxt_st.tout = 1'b0;
    end
    else if (ui_tick)
    begin
      if (st_ff.tcnt == half - 6'h01)
      begin
        nxt_st.tcnt = 6'h00;
        nxt_st.tout = ~st_ff.tout;
      end
      else
        nxt_st.tcnt = st_ff.tcnt + 6'h01;
    end
    // Divided reference outputs
    if (ref_tick)
      nxt_st.rcnt = st_ff.rcnt + 2'h1;
    if (c_code == cop_pkg::DIVREF_OFF)
      nxt_st.cout = 1'b0;
    else if (ref_tick && ((st_ff.rcnt & c_mask) == c_mask))
      nxt_st.cout = ~st_ff.cout;
    if (d_code == cop_pkg::DIVREF_OFF || c_code == cop_pkg::DIVREF_OFF)
      nxt_st.dout = 1'b0;
    else if (ref_tick && ((st_ff.rcnt & d_mask) == d_mask))
      nxt_st.dout = ~st_ff.dout;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= '0;
      st_ff.pe <= cop_pkg::PREEMPH_RST;
      st_ff.trig <= cop_pkg::TRIG_CTRL_RST;
      st_ff.ovr <= cop_pkg::MULT_OVR_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign reg_rdata = st_ff.rdata;
  assign lane_preemphasis_code = st_ff.pe[cop_pkg::PE_MSB:cop_pkg::PE_LSB];
  assign trigger_out_enable = st_ff.trig[cop_pkg::TRIG_EN_BIT];
  assign trigger_out_select = st_ff.trig[cop_pkg::TRIG_SEL_MSB:cop_pkg::TRIG_SEL_LSB];
  assign trigger_out_pair = st_ff.tout;
  assign multiplier_enable = ovr_en ? st_ff.ovr[cop_pkg::MULT_EN_BIT]
                                    : st_ff.sy2[cop_pkg::SY_MEN];
  assign single_ended_ref_select = ovr_en ? st_ff.ovr[cop_pkg::SE_REF_BIT]
                                          : st_ff.sy2[cop_pkg::SY_REFSEL];
  assign first_divref_select = c_code;
  assign second_divref_select = (c_code == cop_pkg::DIVREF_OFF) ? cop_pkg::DIVREF_OFF : d_code;
  assign first_divref_out = st_ff.cout;
  assign second_divref_out = st_ff.dout;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_pe_write;
    reg_wr && reg_addr == cop_pkg::PREEMPH_OFS;
  endsequence
  property p_pe_global;
    s_pe_write |=> lane_preemphasis_code == $past(reg_wdata[3:0]);
  endproperty
  a_pe_global: assert property (p_pe_global) else $error("pre-emphasis code not applied");

  property p_trig_off;
    !trigger_out_enable |=> !trigger_out_pair;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger output active while off");

  property p_tstamp;
    trigger_out_enable && trigger_out_select == cop_pkg::TRIG_TSTAMP
      |=> trigger_out_pair == $past(st_ff.sy2[cop_pkg::SY_TSTAMP]);
  endproperty
  a_tstamp: assert property (p_tstamp) else $error("timestamp not resampled");

  property p_ui16_steady;
    trigger_out_enable && trigger_out_select == cop_pkg::TRIG_UI16 && !ser_reinit && ui_tick
      && st_ff.tcnt != 6'h07 |=> $stable(trigger_out_pair);
  endproperty
  a_ui16_steady: assert property (p_ui16_steady) else $error("16 UI clock toggled early");

  property p_reinit;
    trigger_out_enable && trigger_out_select <= cop_pkg::TRIG_UI64 && ser_reinit
      |=> !trigger_out_pair && st_ff.tcnt == 6'h00;
  endproperty
  a_reinit: assert property (p_reinit) else $error("clock survived serializer restart");

  property p_strap;
    !ovr_en |-> first_divref_select == {st_ff.sy2[cop_pkg::SY_CFGB], st_ff.sy2[cop_pkg::SY_CFGA]}
      && multiplier_enable == st_ff.sy2[cop_pkg::SY_MEN];
  endproperty
  a_strap: assert property (p_strap) else $error("strap pins ignored in pin mode");

  sequence s_ovr_write;
    reg_wr && reg_addr == cop_pkg::MULT_OVR_OFS && reg_wdata[7];
  endsequence
  property p_ovr;
    s_ovr_write |=> multiplier_enable == $past(reg_wdata[0])
      && single_ended_ref_select == $past(reg_wdata[1])
      && first_divref_select == $past(reg_wdata[3:2]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override values not applied");

  property p_second_gated;
    first_divref_select == cop_pkg::DIVREF_OFF |=> !second_divref_out;
  endproperty
  a_second_gated: assert property (p_second_gated) else $error("second output runs alone");

  property p_readback;
    reg_rd && !reg_wr && reg_addr == cop_pkg::TRIG_CTRL_OFS |=> reg_rdata == $past(st_ff.trig);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

endmodule : cop_regs
`default_nettype wire

// file: testbench/cop_regs_tb.sv
// Self-checking bench for the clock output and multiplier override registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic ui_tick = 1'b0;
  logic ser_reinit = 1'b0;
  logic tstamp = 1'b0;
  logic pin_men = 1'b0;
  logic pin_ref = 1'b0;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  logic ref_tick = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] pe_code;
  logic trig_en;
  logic [2:0] trig_sel;
  logic trig_out;
  logic mult_en;
  logic se_sel;
  logic [1:0] first_sel;
  logic [1:0] second_sel;
  logic first_out;
  logic second_out;
  wire logic [7:0] eff;
  int mismatches = 0;
  int compares = 0;
  assign eff = {2'h0, mult_en, se_sel, first_sel, second_sel};
  always #2.5 clk_sys = ~clk_sys;
  cop_regs dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lane_preemphasis_code(pe_code), .ui_tick(ui_tick), .ser_reinit(ser_reinit),
    .timestamp_in_pair(tstamp), .trigger_out_enable(trig_en), .trigger_out_select(trig_sel),
    .trigger_out_pair(trig_out), .multiplier_enable_pin(pin_men), .ref_select_pin(pin_ref),
    .clock_config_pin_a(pin_a), .clock_config_pin_b(pin_b), .ref_tick(ref_tick),
    .multiplier_enable(mult_en), .single_ended_ref_select(se_sel),
    .first_divref_select(first_sel), .second_divref_select(second_sel),
    .first_divref_out(first_out), .second_divref_out(second_out));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask : step
  // Strobe dropped for a cycle so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    chk(reg_rdata, e, "read data");
  endtask : rd
  task automatic hi_len(output int n);
    int g;
    g = 0;
    n = 0;
    while (trig_out !== 1'b1 && g < 200)
    begin
      step(1);
      g++;
    end
    while (trig_out === 1'b1 && n < 200)
    begin
      step(1);
      n++;
    end
    if (g == 200 || n == 200)
    begin
      mismatches++;
      $display("mismatch at %0t: trigger output stuck", $time);
      end_of_test();
    end
  endtask : hi_len
  task automatic t_regs();
    rd(cop_pkg::PREEMPH_OFS, cop_pkg::PREEMPH_RST);
    rd(cop_pkg::TRIG_CTRL_OFS, cop_pkg::TRIG_CTRL_RST);
    rd(cop_pkg::MULT_OVR_OFS, cop_pkg::MULT_OVR_RST);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(cop_pkg::PREEMPH_OFS, 8'h0a);
    chk({4'h0, pe_code}, 8'h0a, "lane code");
    rd(cop_pkg::PREEMPH_OFS, 8'h0a);
    $display("test regs done");
  endtask : t_regs
  task automatic t_trigger();
    int n;
    ui_tick = 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      wr(cop_pkg::TRIG_CTRL_OFS, 8'h00);
      wr(cop_pkg::TRIG_CTRL_OFS, 8'h80 | 8'(m));
      chk({trig_en, 4'h0, trig_sel}, 8'h80 | 8'(m), "trigger fields");
      hi_len(n);
      chk(8'(n), 8'(8 << m), "half period");
    end
    ser_reinit = 1'b1;
    step(3);
    chk({7'h00, trig_out}, 8'h00, "reinit stop");
    ser_reinit = 1'b0;
    wr(cop_pkg::TRIG_CTRL_OFS, 8'h00);
    wr(cop_pkg::TRIG_CTRL_OFS, 8'h83);
    tstamp = 1'b1;
    step(5);
    chk({7'h00, trig_out}, 8'h01, "timestamp high");
    tstamp = 1'b0;
    step(5);
    chk({7'h00, trig_out}, 8'h00, "timestamp low");
    tstamp = 1'b1;
    wr(cop_pkg::TRIG_CTRL_OFS, 8'h03);
    step(20);
    chk({7'h00, trig_out}, 8'h00, "disabled");
    // Reserved mode picked while off, then enabled: output must stay low
    wr(cop_pkg::TRIG_CTRL_OFS, 8'h07);
    wr(cop_pkg::TRIG_CTRL_OFS, 8'h87);
    step(20);
    chk({7'h00, trig_out}, 8'h00, "reserved mode");
    wr(cop_pkg::TRIG_CTRL_OFS, 8'h00);
    $display("test trigger done");
  endtask : t_trigger
  task automatic ovr_case(input logic [7:0] w, input logic [7:0] e, input int t1, input int t2);
    int c1;
    int c2;
    logic p1;
    logic p2;
    c1 = 0;
    c2 = 0;
    wr(cop_pkg::MULT_OVR_OFS, w);
    chk(eff, e, "effective controls");
    step(2);
    for (int i = 0; i < 8; i++)
    begin
      p1 = first_out;
      p2 = second_out;
      step(1);
      c1 += int'(p1 !== first_out);
      c2 += int'(p2 !== second_out);
    end
    chk(8'(c1), 8'(t1), "first toggles");
    chk(8'(c2), 8'(t2), "second toggles");
    rd(cop_pkg::MULT_OVR_OFS, w);
  endtask : ovr_case
  task automatic t_override();
    pin_a = 1'b1;
    pin_men = 1'b1;
    pin_ref = 1'b1;
    ref_tick = 1'b1;
    step(3);
    chk(eff, 8'h35, "pin mode controls");
    ovr_case(8'hb2, 8'h10, 0, 0);
    ovr_case(8'ha5, 8'h26, 8, 4);
    ovr_case(8'hbd, 8'h2f, 2, 2);
    $display("test override done");
  endtask : t_override
  initial
  begin
    step(5);
    rstn = 1'b1;
    t_regs();
    t_trigger();
    t_override();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
